// File: core/port_logic_consts.vh
// Constants for the port logic clock, reset and synchronizer block
`ifndef PORT_LOGIC_CONSTS_VH
`define PORT_LOGIC_CONSTS_VH

// Register byte offsets
`define PL_CTRL_OFFSET       12'h000
`define PL_SYNC_OFFSET       12'h004
`define PL_STATUS_OFFSET     12'h008
`define PL_ADDR_W            12

// Control register layout
`define PL_CTRL_ENABLE_BIT   31
`define PL_CTRL_SEL_HI       12
`define PL_CTRL_SEL_LO       8
`define PL_CTRL_RESET        32'h00001400

// Synchronizer control layout
`define PL_SYNC_IO_LO        0
`define PL_SYNC_CHIP_LO      8
`define PL_SYNC_RESET        32'h00000000

// Clock source codes
`define PL_SEL_IO_LAST       5'h07
`define PL_SEL_CHIP_LAST     5'h0f
`define PL_SEL_PERI_ACT      5'h10
`define PL_SEL_PERI_DPSLP    5'h11
`define PL_SEL_LOW_FREQ      5'h13
`define PL_SEL_SYS_CLK       5'h1f

// Power modes
`define PL_MODE_ACTIVE       2'h0
`define PL_MODE_SLEEP        2'h1
`define PL_MODE_DEEP_SLEEP   2'h2

// Start-up hold in block clock cycles
`define PL_STARTUP_CYCLES    2'h2
`define PL_STARTUP_SYS_CYC   2'h3

`endif

// File: core/input_sync_stage.v
// Two-stage synchronizer with bypass, advanced on block clock ticks
`timescale 1ns/1ps
`default_nettype none

module input_sync_stage (
   input  wire sys_clk_i,
   input  wire rst_b_i,
   input  wire tick_i,
   input  wire clear_i,
   input  wire sync_en_i,
   input  wire bypass_i,
   input  wire data_i,
   output reg  data_o
);

   reg first_stage;
   reg second_stage;

   // First stage feeds only the second stage
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         first_stage  <= 1'b0;
         second_stage <= 1'b0;
      end else if (clear_i) begin
         first_stage  <= 1'b0;
         second_stage <= 1'b0;
      end else if (tick_i) begin
         first_stage  <= data_i;
         second_stage <= first_stage;
      end
   end

   // Cleared enable or start-up bypass passes the raw input
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         data_o <= 1'b0;
      else if (sync_en_i && !bypass_i)
         data_o <= second_stage;
      else
         data_o <= data_i;
   end

endmodule // input_sync_stage

`default_nettype wire

// File: core/port_logic_clock_reset_sync.v
// Clock and reset selection with input synchronizers for the port logic fabric
//
// Overview of operation
// - One selected clock and one selected reset feed all fabric parts.
// - Control bits 12 to 8 choose the fabric clock and reset pair.
// - Selected clock runs synchronizers and fabric; selected reset clears fabric asynchronously.
// - Codes 0-7 clock from pin i, 8-15 from mux output i; reset inactive.
// - Code 16 uses peripheral clock; reset asserted outside Active mode.
// - Code 17 uses peripheral clock, reset from the Deep-Sleep reset input; clock stops in Deep-Sleep.
// - Code 19 uses 40 kHz clock, running in every power mode.
// - Codes 20-30 give constant-low clock; software picks them while disabled.
// - Code 31 uses system clock; fully working three cycles after enable.
// - Enabled passes clock and reset; disabled gates clock, holds reset.
// - Reset held and bypass active for first two block cycles after enabling, three for code 31.
// - Each pin and mux input optionally passes a two-flop block-clock synchronizer.
// - Per-pin port-side and chip-side enable bits select synchronized or bypass.
// - Peripheral clock exists only in Active and Sleep modes.
`timescale 1ns/1ps
`default_nettype none
`include "port_logic_consts.vh"

module port_logic_clock_reset_sync #(
   parameter WIDTH = 8
) (
   input  wire                 sys_clk_i,
   input  wire                 rst_b_i,
   // APB slave
   input  wire                 psel_i,
   input  wire                 penable_i,
   input  wire                 pwrite_i,
   input  wire [11:0]          paddr_i,
   input  wire [31:0]          pwdata_i,
   output reg  [31:0]          prdata_o,
   output reg                  pready_o,
   output reg                  pslverr_o,
   // Clock and reset sources
   input  wire                 periph_clk_i,
   input  wire                 low_freq_clock_i,
   input  wire                 sys_act_rst_b_i,
   input  wire                 sys_dpslp_rst_b_i,
   input  wire                 low_freq_reset_low_i,
   input  wire [1:0]           power_mode_i,
   // Port and multiplexer inputs
   input  wire [WIDTH-1:0]     io_data_i,
   input  wire [WIDTH-1:0]     chip_data_i,
   // Fabric side
   output reg                  clk_block_o,
   output reg                  rst_block_b_o,
   output reg                  bypass_o,
   output wire [WIDTH-1:0]     io_data_o,
   output wire [WIDTH-1:0]     chip_data_o
);

   reg  [31:0]           ctrl_reg;
   reg  [31:0]           sync_reg;
   reg                   sel_level_q;
   reg                   sys_phase;
   reg  [1:0]            startup_cnt;
   reg                   enable_q;
   reg                   sel_level;
   reg                   sel_reset_b;
   reg                   next_clk_level;
   reg  [31:0]           read_value;
   reg                   addr_ok;
   wire [4:0]            clock_sel;
   wire                  enable;
   wire                  tick;
   wire                  sys_sel;
   wire                  periph_live;
   wire [1:0]            startup_need;
   wire                  startup_done;
   wire                  apb_setup;
   wire                  apb_write;
   wire                  enable_rise;

   assign clock_sel = ctrl_reg[`PL_CTRL_SEL_HI:`PL_CTRL_SEL_LO];
   assign enable    = ctrl_reg[`PL_CTRL_ENABLE_BIT];
   assign sys_sel   = (clock_sel == `PL_SEL_SYS_CLK);

   // Peripheral divider output is dead in Deep-Sleep
   assign periph_live = periph_clk_i &&
                        (power_mode_i == `PL_MODE_ACTIVE ||
                         power_mode_i == `PL_MODE_SLEEP);

   // Source selection: level of the chosen clock and its paired reset
   always @* begin
      sel_level   = 1'b0;
      sel_reset_b = 1'b1;
      if (clock_sel <= `PL_SEL_IO_LAST) begin
         sel_level   = io_data_i[clock_sel[2:0]];
         sel_reset_b = 1'b1;
      end else if (clock_sel <= `PL_SEL_CHIP_LAST) begin
         sel_level   = chip_data_i[clock_sel[2:0]];
         sel_reset_b = 1'b1;
      end else begin
         case (clock_sel)
            `PL_SEL_PERI_ACT: begin
               sel_level   = periph_live;
               sel_reset_b = sys_act_rst_b_i &&
                             (power_mode_i == `PL_MODE_ACTIVE);
            end
            `PL_SEL_PERI_DPSLP: begin
               sel_level   = periph_live;
               sel_reset_b = sys_dpslp_rst_b_i;
            end
            `PL_SEL_LOW_FREQ: begin
               sel_level   = low_freq_clock_i;
               sel_reset_b = low_freq_reset_low_i;
            end
            `PL_SEL_SYS_CLK: begin
               sel_level   = 1'b0;
               sel_reset_b = 1'b1;
            end
            default: begin
               // Code 18 and codes 20 to 30 deliver no edges
               sel_level   = 1'b0;
               sel_reset_b = 1'b1;
            end
         endcase
      end
   end

   // Block clock tick: rising edge of the chosen source, or every cycle for
   // the system clock; gated off while disabled
   assign tick = enable && (sys_sel || (sel_level && !sel_level_q));

   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sel_level_q <= 1'b0;
         sys_phase   <= 1'b0;
         enable_q    <= 1'b0;
      end else begin
         sel_level_q <= sel_level;
         sys_phase   <= sys_sel ? ~sys_phase : 1'b0;
         enable_q    <= enable;
      end
   end

   // Clock seen by the fabric; the system clock choice is shown as a
   // half-rate square wave because the output is registered
   always @* begin
      if (!enable)
         next_clk_level = 1'b0;
      else if (sys_sel)
         next_clk_level = ~sys_phase;
      else
         next_clk_level = sel_level;
   end

   // Start-up hold counts block clock ticks after the enable
   assign enable_rise  = enable && !enable_q;
   assign startup_need = sys_sel ? `PL_STARTUP_SYS_CYC : `PL_STARTUP_CYCLES;
   assign startup_done = (startup_cnt >= startup_need);

   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         startup_cnt <= 2'h0;
      else if (!enable || enable_rise)
         startup_cnt <= 2'h0;
      else if (tick && !startup_done)
         startup_cnt <= startup_cnt + 2'h1;
   end

   // Fabric clock, reset and bypass, all registered
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         clk_block_o   <= 1'b0;
         rst_block_b_o <= 1'b0;
         bypass_o      <= 1'b1;
      end else begin
         clk_block_o   <= next_clk_level;
         // Disabled or still starting: reset held, fabric state at zero
         rst_block_b_o <= enable && startup_done && sel_reset_b;
         bypass_o      <= !(enable && startup_done);
      end
   end

   // Per-pin synchronizers, stepped by the block clock tick. The fabric
   // boundary stays asynchronous to other logic, so consumers of these
   // outputs must resynchronize them.
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_sync
         input_sync_stage u_io_sync (
            .sys_clk_i (sys_clk_i),
            .rst_b_i   (rst_b_i),
            .tick_i    (tick),
            .clear_i   (!enable),
            .sync_en_i (sync_reg[`PL_SYNC_IO_LO + g]),
            .bypass_i  (bypass_o),
            .data_i    (io_data_i[g]),
            .data_o    (io_data_o[g])
         );
         input_sync_stage u_chip_sync (
            .sys_clk_i (sys_clk_i),
            .rst_b_i   (rst_b_i),
            .tick_i    (tick),
            .clear_i   (!enable),
            .sync_en_i (sync_reg[`PL_SYNC_CHIP_LO + g]),
            .bypass_i  (bypass_o),
            .data_i    (chip_data_i[g]),
            .data_o    (chip_data_o[g])
         );
      end
   endgenerate

   // APB slave: answer registered in the setup cycle, so pready rises in
   // the first access cycle and every transfer takes exactly two cycles
   assign apb_setup = psel_i && !penable_i;
   assign apb_write = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;

   always @* begin
      addr_ok    = 1'b1;
      read_value = 32'h00000000;
      case (paddr_i)
         `PL_CTRL_OFFSET:
            read_value = ctrl_reg;
         `PL_SYNC_OFFSET:
            read_value = sync_reg;
         `PL_STATUS_OFFSET:
            read_value = {26'h0000000, startup_cnt, bypass_o,
                          rst_block_b_o, clk_block_o, enable};
         default:
            addr_ok = 1'b0;
      endcase
   end

   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
      end else if (apb_setup) begin
         pready_o  <= 1'b1;
         pslverr_o <= !addr_ok;
         prdata_o  <= (pwrite_i || !addr_ok) ? 32'h00000000 : read_value;
      end else begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
      end
   end

   // Control writes keep only the enable bit and the select field (sync writes keep bits 15 to 0); a select
   // change while enabled may glitch the fabric clock, so software should
   // disable first and park on a constant-low code
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_reg <= `PL_CTRL_RESET;
         sync_reg <= `PL_SYNC_RESET;
      end else if (apb_write) begin
         case (paddr_i)
            `PL_CTRL_OFFSET: begin
               ctrl_reg <= 32'h00000000;
               ctrl_reg[`PL_CTRL_ENABLE_BIT] <= pwdata_i[`PL_CTRL_ENABLE_BIT];
               ctrl_reg[`PL_CTRL_SEL_HI:`PL_CTRL_SEL_LO] <=
                  pwdata_i[`PL_CTRL_SEL_HI:`PL_CTRL_SEL_LO];
            end
            `PL_SYNC_OFFSET:
               sync_reg <= {16'h0000, pwdata_i[15:0]};
            default: begin
               ctrl_reg <= ctrl_reg;
               sync_reg <= sync_reg;
            end
         endcase
      end
   end

endmodule // port_logic_clock_reset_sync

`default_nettype wire

// File: test/port_logic_props.sv
// Checker bound to the port logic clock, reset and synchronizer block
`timescale 1ns/1ps
`default_nettype none
`include "port_logic_consts.vh"
module port_logic_props #(parameter WIDTH = 8) (
   input wire logic             sys_clk_i,
   input wire logic             rst_b_i,
   input wire logic             psel_i,
   input wire logic             penable_i,
   input wire logic             pwrite_i,
   input wire logic [11:0]      paddr_i,
   input wire logic [31:0]      pwdata_i,
   input wire logic             pready_o,
   input wire logic             pslverr_o,
   input wire logic [1:0]       power_mode_i,
   input wire logic [WIDTH-1:0] io_data_i,
   input wire logic             clk_block_o,
   input wire logic             rst_block_b_o,
   input wire logic             bypass_o,
   input wire logic [WIDTH-1:0] io_data_o
);
   logic             en_q;
   logic [4:0]       sel_q;
   logic [WIDTH-1:0] io_sync_q;
   wire              wr_done = psel_i && penable_i && pready_o && pwrite_i;
   // Code 19 is the low-frequency clock, so it is not part of the quiet set
   wire              low_sel = (sel_q == 5'h12) || (sel_q >= 5'h14 && sel_q <= 5'h1e);
   // Shadow of the written controls, since the registers are not visible here
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         en_q      <= 1'b0;
         sel_q     <= 5'h14;
         io_sync_q <= '0;
      end else if (wr_done && paddr_i == `PL_CTRL_OFFSET) begin
         en_q  <= pwdata_i[31];
         sel_q <= pwdata_i[12:8];
      end else if (wr_done && paddr_i == `PL_SYNC_OFFSET) begin
         io_sync_q <= pwdata_i[WIDTH-1:0];
      end
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready_o |=> !pready_o)
      else $error("ready held too long");
   a_bad_addr_err: assert property (psel_i && !penable_i && paddr_i > 12'h008 |=> pslverr_o)
      else $error("no error on unmapped address");
   a_disabled_quiet: assert property (!en_q && $past(!en_q) |-> bypass_o && !rst_block_b_o && !clk_block_o)
      else $error("disabled fabric not held");
   a_bypass_in_reset: assert property (bypass_o |-> !rst_block_b_o)
      else $error("reset released during bypass");
   a_const_low_clk: assert property (low_sel && $past(low_sel) |-> !clk_block_o)
      else $error("clock edge on constant low code");
   a_pin_clk_follow: assert property (en_q && !bypass_o && sel_q < 5'h08 && $stable(sel_q)
      |-> clk_block_o == $past(io_data_i[sel_q]))
      else $error("block clock does not follow pin");
   a_pin_rst_off: assert property (en_q && !bypass_o && sel_q < 5'h10 && $stable(sel_q) |-> rst_block_b_o)
      else $error("pin clock code with reset active");
   a_act_mode_rst: assert property (sel_q == 5'h10 && $stable(sel_q) && $past(power_mode_i) != 2'h0
      |-> !rst_block_b_o)
      else $error("reset not active outside Active mode");
   a_sys_startup: assert property ($rose(en_q) && sel_q == 5'h1f |-> bypass_o [*3] ##[1:3] !bypass_o)
      else $error("system clock start-up length wrong");
   a_io_bypass_path: assert property (io_sync_q == '0 && $past(io_sync_q) == '0 && $past(rst_b_i)
      |-> io_data_o == $past(io_data_i))
      else $error("bypassed pin not one cycle late");
   c_sys_start: cover property ($rose(en_q) && sel_q == 5'h1f);
   c_low_freq: cover property (sel_q == 5'h13 && $rose(clk_block_o));
   c_bad_addr: cover property (pslverr_o);
endmodule // port_logic_props
bind port_logic_clock_reset_sync port_logic_props #(.WIDTH(WIDTH)) u_props (
   .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .power_mode_i(power_mode_i), .io_data_i(io_data_i),
   .clk_block_o(clk_block_o), .rst_block_b_o(rst_block_b_o), .bypass_o(bypass_o),
   .io_data_o(io_data_o)
);
`default_nettype wire

// File: test/port_sources_model.sv
// Clock sources seen by the block: divided peripheral clock and low-frequency clock
`timescale 1ns/1ps
`default_nettype none
module port_sources_model (
   input  wire logic       sys_clk_i,
   input  wire logic       rst_b_i,
   input  wire logic [1:0] power_mode_i,
   output var  logic       periph_clk_o,
   output wire logic       low_freq_clock_o
);
   logic [3:0] div_q;
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_q        <= 4'h0;
         periph_clk_o <= 1'b0;
      end else begin
         div_q <= div_q + 4'h1;
         // Divider output holds in Deep-Sleep, so no edges reach the block
         if (power_mode_i != 2'h2) periph_clk_o <= div_q[1];
      end
   end
   // The bench only looks at the fabric side through whole-cycle waits, never
   // assuming phase alignment with these sources
   // Scaled far above 40 kHz to keep runs short; runs in every mode
   assign low_freq_clock_o = div_q[3];
endmodule // port_sources_model
`default_nettype wire

// File: test/port_logic_clock_reset_sync_tb_top.sv
// Self-checking bench for the port logic clock, reset and synchronizer block
`timescale 1ns/1ps
`default_nettype none
`include "port_logic_consts.vh"
module port_logic_clock_reset_sync_tb_top;
   logic        sys_clk_i;
   logic        rst_b_i;
   logic        psel_i;
   logic        penable_i;
   logic        pwrite_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic        periph_clk_i;
   logic        low_freq_clock_i;
   logic        rst_on_b;
   logic [1:0]  power_mode_i;
   logic [7:0]  io_data_i;
   logic [7:0]  chip_data_i;
   logic        clk_block_o;
   logic        rst_block_b_o;
   logic        bypass_o;
   logic [7:0]  io_data_o;
   logic [7:0]  chip_data_o;
   int          errors = 0;
   int          samples_checked = 0;
   logic [4:0]  code_t [9] = '{5'h00, 5'h08, 5'h10, 5'h11, 5'h13, 5'h14, 5'h1e, 5'h12, 5'h1f};
   logic [1:0]  mode_t [9] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0};
   logic        tog_t [9]  = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
   logic        rst_t [9]  = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
   port_logic_clock_reset_sync #(.WIDTH(8)) dut (
      .sys_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .periph_clk_i, .low_freq_clock_i,
      .sys_act_rst_b_i(rst_on_b), .sys_dpslp_rst_b_i(rst_on_b),
      .low_freq_reset_low_i(rst_on_b), .power_mode_i, .io_data_i, .chip_data_i,
      .clk_block_o, .rst_block_b_o, .bypass_o, .io_data_o, .chip_data_o
   );
   port_sources_model u_src (
      .sys_clk_i, .rst_b_i, .power_mode_i,
      .periph_clk_o(periph_clk_i), .low_freq_clock_o(low_freq_clock_i)
   );
   task automatic close_out;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask
   // Master holds the request until ready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      psel_i   <= 1'b1;
      pwrite_i <= wr;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 16);
      if (n >= 16) begin
         errors++;
         $display("MISMATCH t=%0t no ready from register bus", $time);
         close_out();
      end
      q = prdata_o;
      e = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask
   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      errors++;
      $display("MISMATCH t=%0t run limit reached", $time);
      close_out();
   end
   initial begin : main
      logic [31:0] q;
      logic        e;
      logic        prev;
      int          rises;
      {rst_b_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
      {io_data_i, chip_data_i, power_mode_i} = '0;
      rst_on_b = 1'b1;
      repeat (4) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      apb(1'b0, `PL_CTRL_OFFSET, 32'h0, q, e);
      chk_word(q, 32'h00001400);
      apb(1'b0, `PL_SYNC_OFFSET, 32'h0, q, e);
      chk_word(q, 32'h0);
      apb(1'b1, `PL_STATUS_OFFSET, 32'hffffffff, q, e);
      apb(1'b0, `PL_STATUS_OFFSET, 32'h0, q, e);
      chk_word(q, 32'h8);
      apb(1'b0, 12'h00c, 32'h0, q, e);
      chk_flag(e, 1'b1);
      io_data_i   <= 8'ha5;
      chip_data_i <= 8'h3c;
      repeat (2) @(posedge sys_clk_i);
      chk_word({io_data_o, chip_data_o}, 32'ha53c);
      for (int i = 0; i < 9; i++) begin
         power_mode_i <= 2'h0;
         apb(1'b1, `PL_CTRL_OFFSET, 32'h00001400, q, e);
         apb(1'b1, `PL_CTRL_OFFSET, 32'h80000000 | (32'(code_t[i]) << 8), q, e);
         rises = 0;
         prev = 1'b0;
         for (int c = 0; c < 96; c++) begin
            @(posedge sys_clk_i);
            io_data_i   <= ~io_data_i;
            chip_data_i <= ~chip_data_i;
            if (c == 52) power_mode_i <= mode_t[i];
            if (c > 56 && clk_block_o && !prev) rises++;
            prev = clk_block_o;
         end
         chk_flag(rises != 0, tog_t[i]);
         chk_flag(rst_block_b_o, rst_t[i]);
      end
      apb(1'b1, `PL_SYNC_OFFSET, 32'h0000ffff, q, e);
      io_data_i   <= 8'h00;
      chip_data_i <= 8'h00;
      repeat (8) @(posedge sys_clk_i);
      io_data_i   <= 8'h5a;
      chip_data_i <= 8'hc3;
      repeat (2) @(posedge sys_clk_i);
      chk_word({io_data_o, chip_data_o}, 32'h0);
      repeat (4) @(posedge sys_clk_i);
      chk_word({io_data_o, chip_data_o}, 32'h5ac3);
      apb(1'b1, `PL_CTRL_OFFSET, 32'h00001400, q, e);
      repeat (3) @(posedge sys_clk_i);
      chk_flag(bypass_o, 1'b1);
      close_out();
   end
endmodule // port_logic_clock_reset_sync_tb_top
`default_nettype wire
